//--- hdl/rsp_pkg.sv
package rsp_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int          RSP_BYTE_BITS   = 8;
    localparam int          RSP_ADDR_BITS   = 7;
    localparam int          RSP_BIT_CNT_W   = 3;
    localparam logic [2:0]  RSP_LAST_BIT    = 3'h7;
    localparam logic        RSP_DIR_READ    = 1'b1;

    // ------------------------------------------------------------
    // Register groups
    // ------------------------------------------------------------
    localparam logic [6:0]  RSP_G1_LAST     = 7'h1F;
    localparam logic [6:0]  RSP_G2_FIRST    = 7'h20;
    localparam logic [6:0]  RSP_G2_LAST     = 7'h2A;
    localparam logic [6:0]  RSP_G2_EXTRA    = 7'h34;
    localparam logic [6:0]  RSP_FIFO_ADDR   = 7'h32;
    localparam logic [6:0]  RSP_STATUS_ADDR = 7'h30;
    localparam logic [6:0]  RSP_ID_ADDR     = 7'h1F;
    localparam int          RSP_NUM_REGS    = 128;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RSP_REG_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // Host-side timing, for reference only
    // ------------------------------------------------------------
    localparam int          RSP_CLK_MHZ     = 20;
    localparam int          RSP_HOP_US      = 150;
    localparam int          RSP_HOP_AC_US   = 350;
    localparam int          RSP_GAP_FIFO_NS = 350;
    localparam int          RSP_GAP_NS      = 83;
    localparam int          RSP_GAP_FIFO_CYC =
        (RSP_GAP_FIFO_NS * RSP_CLK_MHZ + 999) / 1000;
    localparam int          RSP_GAP_CYC     =
        (RSP_GAP_NS * RSP_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        RSP_ST_CMD  = 3'b001,
        RSP_ST_WR   = 3'b010,
        RSP_ST_RD   = 3'b100
    } rsp_state_e;

endpackage

//--- hdl/rsp_port.sv
`timescale 1ns/1ps
module rsp_port
    import rsp_pkg::*;
#(
    parameter logic [15:0] SILICON_ID = 16'h0A5C  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial pins, sampled synchronously
    input  wire logic        spi_ss_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    // Device side
    input  wire logic [15:0] status_word_register,
    output logic             fifo_wr_stb,
    output logic [7:0]       fifo_wr_data,
    output logic             fifo_rd_stb,
    input  wire logic [7:0]  fifo_rd_data
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rsp_state_e       state;
    logic             sck_d;
    logic [2:0]       bit_cnt;
    logic [7:0]       sh_in;
    logic [7:0]       sh_out;
    logic [6:0]       addr;
    logic             hi_phase;
    logic [7:0]       wr_hi;
    logic             mem_we;
    logic [15:0]      mem_wdata;
    logic [15:0]      mem_rdata;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic is_byte_reg(input logic [6:0] a);
        return (a == RSP_FIFO_ADDR) || (a == RSP_G2_EXTRA) ||
               ((a >= RSP_G2_FIRST) && (a <= RSP_G2_LAST));
    endfunction

    wire        active    = ~spi_ss_n;
    wire        rise      = active & spi_sck & ~sck_d;
    wire        fall      = active & ~spi_sck & sck_d;
    wire        byte_done = rise && (bit_cnt == RSP_LAST_BIT);
    wire [7:0]  byte_in   = {sh_in[6:0], spi_mosi};
    wire        is_fifo   = (addr == RSP_FIFO_ADDR);
    wire        byte_reg  = is_byte_reg(addr);
    wire [6:0]  cmd_addr  = byte_in[6:0];
    wire        cmd_rd    = (byte_in[7] == RSP_DIR_READ);
    wire [15:0] rd_word   = (addr == RSP_ID_ADDR) ? SILICON_ID
                          : (addr == RSP_STATUS_ADDR) ? status_word_register
                          : mem_rdata;
    wire [7:0]  rd_byte   = is_fifo ? fifo_rd_data
                          : byte_reg ? rd_word[7:0]
                          : (hi_phase ? rd_word[15:8] : rd_word[7:0]);
    wire        adv       = ~is_fifo && (byte_reg || !hi_phase);
    wire [6:0]  next_addr = adv ? addr + 7'h01 : addr;

    // Next byte to shift out, loaded on each byte boundary
    wire        go_read   = (state == RSP_ST_CMD) ? cmd_rd
                          : (state == RSP_ST_RD);
    wire [7:0]  stat_byte = status_word_register[15:8];
    wire [7:0]  next_out  = go_read ? rd_byte : stat_byte;

    // Write path: byte registers store directly, others pair hi/lo
    assign mem_we    = byte_done && (state == RSP_ST_WR) && !is_fifo &&
                       (byte_reg || !hi_phase);
    assign mem_wdata = byte_reg ? {8'h00, byte_in} : {wr_hi, byte_in};

    rsp_reg_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_we),
        .wr_addr (addr),
        .wr_data (mem_wdata),
        .rd_addr ((state == RSP_ST_CMD) ? cmd_addr : addr),
        .rd_data (mem_rdata)
    );

    assign spi_miso    = sh_out[7];
    assign spi_miso_oe = active;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || !active) begin
            state    <= RSP_ST_CMD;
            bit_cnt  <= 3'h0;
            sh_in    <= 8'h00;
            hi_phase <= 1'b1;
        end else if (rise) begin
            sh_in   <= byte_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                unique case (state)
                    RSP_ST_CMD: begin
                        state    <= cmd_rd ? RSP_ST_RD : RSP_ST_WR;
                        hi_phase <= 1'b1;
                    end
                    RSP_ST_WR, RSP_ST_RD: begin
                        hi_phase <= byte_reg ? 1'b1 : ~hi_phase;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_d <= 1'b0;
            addr  <= 7'h00;
            wr_hi <= 8'h00;
        end else begin
            sck_d <= spi_sck;
            if (byte_done && state == RSP_ST_CMD) begin
                addr <= cmd_addr;
            end else if (byte_done) begin
                addr <= next_addr;
            end
            if (byte_done && state == RSP_ST_WR && hi_phase) begin
                wr_hi <= byte_in;
            end
        end
    end

    // Output shifter: status during command, then loaded per byte.
    // The load waits for the first fall after a byte ends, by which
    // time the memory has presented its read data.
    always_ff @(posedge clk) begin
        if (sys_rst || !active) begin
            sh_out <= stat_byte;
        end else if (fall && bit_cnt == 3'h0) begin
            sh_out <= next_out;
        end else if (fall) begin
            sh_out <= {sh_out[6:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // FIFO strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fifo_wr_stb  <= 1'b0;
            fifo_rd_stb  <= 1'b0;
            fifo_wr_data <= 8'h00;
        end else begin
            fifo_wr_stb  <= byte_done && state == RSP_ST_WR && is_fifo;
            fifo_rd_stb  <= byte_done && state == RSP_ST_RD && is_fifo;
            if (byte_done) begin
                fifo_wr_data <= byte_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_miso_idle_hiz: assert property (
        @(posedge clk) disable iff (sys_rst)
        spi_ss_n |-> !spi_miso_oe)
        else $error("MISO driven while deselected");
    a_abort_resets: assert property (
        @(posedge clk) disable iff (sys_rst)
        spi_ss_n |=> (state == RSP_ST_CMD && bit_cnt == 3'h0))
        else $error("Partial byte not discarded");
    a_fifo_no_adv: assert property (
        @(posedge clk) disable iff (sys_rst)
        (byte_done && state != RSP_ST_CMD && is_fifo) |=>
        (addr == RSP_FIFO_ADDR))
        else $error("FIFO address advanced");
    a_fifo_rd_src: assert property (
        @(posedge clk) disable iff (sys_rst)
        fifo_rd_stb |-> ($past(state) == RSP_ST_RD))
        else $error("FIFO popped outside a read");
    a_write_no_rd: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == RSP_ST_WR) |-> !fifo_rd_stb)
        else $error("Read strobe during write");
    a_read_no_wr: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == RSP_ST_RD) |-> !mem_we)
        else $error("Write during read");
    a_cmd_dir: assert property (
        @(posedge clk) disable iff (sys_rst)
        (byte_done && state == RSP_ST_CMD && active) |=>
        (state == ($past(byte_in[7]) ? RSP_ST_RD : RSP_ST_WR)) [*1])
        else $error("Direction decode wrong");
    a_pair_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mem_we && !byte_reg) |-> !hi_phase)
        else $error("Word written on upper byte");
    a_g1_adv: assert property (
        @(posedge clk) disable iff (sys_rst)
        (byte_done && state != RSP_ST_CMD && !byte_reg && hi_phase)
        |=> (addr == $past(addr)))
        else $error("Address advanced mid-word");
    a_idle_status: assert property (
        @(posedge clk) disable iff (sys_rst)
        !active |=> (sh_out == $past(stat_byte)))
        else $error("Status byte not staged while idle");
    a_write_status: assert property (
        @(posedge clk) disable iff (sys_rst)
        (fall && bit_cnt == 3'h0 && state == RSP_ST_WR) |=>
        (sh_out == $past(stat_byte)))
        else $error("Status byte not returned during write");

    c_read: cover property (@(posedge clk) state == RSP_ST_RD);
    c_write: cover property (@(posedge clk) mem_we);
    c_fifo: cover property (@(posedge clk) fifo_wr_stb || fifo_rd_stb);
    c_abort: cover property (@(posedge clk)
        (active && bit_cnt != 3'h0) ##1 !active);
endmodule

//--- hdl/rsp_reg_mem.sv
`timescale 1ns/1ps
module rsp_reg_mem
    import rsp_pkg::*;
#(
    parameter int DEPTH = RSP_NUM_REGS,
    parameter int AW    = 7
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [15:0]   wr_data,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [15:0]   rd_data
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

//--- tb/radio_spi_register_port_tb.sv
`timescale 1ns/1ps
module radio_spi_register_port_tb;
    import rsp_pkg::*;
    localparam logic [15:0] TB_ID = 16'h5A3C; // Arbitrary value
    logic        clk, sys_rst, spi_miso, spi_miso_oe;
    logic        fifo_wr_stb, fifo_rd_stb;
    logic [15:0] status;
    logic [7:0]  fifo_wr_data, fifo_rd_data;
    wire         ss_n, sck, mosi;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          rd_idx     = 0;
    int          exp_idx    = 0;
    logic [15:0] seed       = 16'h0063;
    logic [15:0] ref_mem [128];
    logic [7:0]  tx_b [8];
    logic [7:0]  wr_q [$];
    logic [7:0]  ewr_q [$];

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    rsp_port #(.SILICON_ID(TB_ID)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .spi_ss_n(ss_n), .spi_sck(sck),
        .spi_mosi(mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .status_word_register(status), .fifo_wr_stb(fifo_wr_stb),
        .fifo_wr_data(fifo_wr_data), .fifo_rd_stb(fifo_rd_stb),
        .fifo_rd_data(fifo_rd_data));
    rsp_host_model host_u (
        .clk(clk), .miso(spi_miso), .ss_n(ss_n), .sck(sck), .mosi(mosi));
    assign fifo_rd_data = 8'hC0 + rd_idx[7:0];
    always @(posedge clk) begin
        if (fifo_rd_stb) rd_idx <= rd_idx + 1;
        if (fifo_wr_stb) wr_q.push_back(fifo_wr_data);
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic fill();
        for (int k = 0; k < 8; k++) begin
            seed    = lfsr(seed);
            tx_b[k] = seed[7:0];
        end
        seed   = lfsr(seed);
        status = seed;
    endtask
    // One whole transfer, compared byte by byte with the bench model
    task automatic frame(input logic rd, input logic [6:0] a, input int n);
        logic [7:0] r, e, hi;
        logic [6:0] p;
        p  = a;
        hi = 8'h00;
        host_u.sel(1'b1);
        #1;
        check("oe_on", {7'h00, spi_miso_oe}, 8'h01);
        host_u.shift({rd, a}, 8, r);
        check("status", r, status[15:8]);
        for (int k = 0; k < n; k++) begin
            host_u.shift(tx_b[k], 8, r);
            if (p == RSP_ID_ADDR) e = k[0] ? TB_ID[7:0] : TB_ID[15:8];
            else if (p <= RSP_G1_LAST) e = ref_mem[p][(k[0] ? 7 : 15) -: 8];
            else if (p == RSP_FIFO_ADDR) e = 8'hC0 + exp_idx[7:0];
            else e = ref_mem[p][7:0];
            if (rd) check("rdata", r, e);
            else check("wstat", r, status[15:8]);
            if (p == RSP_FIFO_ADDR) begin
                if (rd) exp_idx++;
                else ewr_q.push_back(tx_b[k]);
            end else if (!rd && p > RSP_G1_LAST) ref_mem[p] = {8'h00, tx_b[k]};
            else if (!rd && k[0]) ref_mem[p] = {hi, tx_b[k]};
            hi = tx_b[k];
            if (p != RSP_FIFO_ADDR && (p > RSP_G1_LAST || k[0])) p++;
        end
        host_u.sel(1'b0);
        #1;
        check("oe_off", {7'h00, spi_miso_oe}, 8'h00);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        logic [7:0] r;
        logic [6:0] a;
        sys_rst = 1'b1;
        status  = 16'h0000;
        for (int i = 0; i < 128; i++) ref_mem[i] = RSP_REG_RESET;
        repeat (3) @(posedge clk);
        #2 sys_rst = 1'b0;
        fill();
        a = 7'(seed % 29);
        frame(1'b0, a, 4);
        host_u.settle(seed[0]);
        fill();
        frame(1'b1, a, 4);
        fill();
        frame(1'b1, a, 3);
        $display("test word registers done");
        fill();
        frame(1'b0, 7'h28, 3);
        frame(1'b0, RSP_G2_EXTRA, 1);
        fill();
        frame(1'b1, 7'h28, 3);
        frame(1'b1, RSP_G2_EXTRA, 1);
        frame(1'b1, RSP_ID_ADDR, 2);
        $display("test byte and id registers done");
        fill();
        frame(1'b0, RSP_FIFO_ADDR, 3);
        frame(1'b1, RSP_FIFO_ADDR, 3);
        check("fifo_wr_n", 8'(wr_q.size()), 8'(ewr_q.size()));
        foreach (ewr_q[i]) check("fifo_wr", wr_q[i], ewr_q[i]);
        check("fifo_rd_n", 8'(rd_idx), 8'(exp_idx));
        $display("test fifo done");
        fill();
        frame(1'b0, 7'h24, 1);
        host_u.sel(1'b1);
        host_u.shift({1'b0, 7'h24}, 8, r);
        host_u.shift(~tx_b[0], 4, r);
        host_u.sel(1'b0);
        fill();
        frame(1'b1, 7'h24, 1);
        $display("test abort done");
        complete_run();
    end
endmodule

//--- tb/rsp_host_model.sv
`timescale 1ns/1ps
module rsp_host_model
    import rsp_pkg::*;
(
    // Clock and serial pins
    input  wire logic clk,
    input  wire logic miso,
    output logic      ss_n,
    output logic      sck,
    output logic      mosi
);
    initial begin
        ss_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Idle and byte gaps stay above the longest minimum spacing
    task automatic sel(input logic on);
        tick(8);
        ss_n = ~on;
        if (!on) mosi = ~mosi;
    endtask
    // Channel changes need the synthesiser settled before more traffic
    task automatic settle(input logic automatic_synth_calibration);
        tick((automatic_synth_calibration ? RSP_HOP_AC_US : RSP_HOP_US)
             * RSP_CLK_MHZ);
    endtask
    task automatic shift(input logic [7:0] tx, input int nb,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            mosi = tx[i];
            tick(4);
            sck   = 1'b1;
            rx[i] = miso;
            tick(4);
            sck   = 1'b0;
        end
        tick(8);
    endtask
endmodule
